//--- rtl/scl_pkg.sv
/*
  scl_pkg: field positions, latch codes and reset values for the synthesizer
  control word latches. Assumes a single 125 MHz clock domain.
*/
package scl_pkg;
  localparam int WORD_W = 32;
  localparam logic [2:0] SEL_CHANNEL = 3'h0;
  localparam logic [2:0] SEL_MODPH = 3'h1;
  localparam logic [2:0] SEL_CFG2 = 3'h2;
  localparam logic [2:0] SEL_BOOST = 3'h3;
  localparam logic [2:0] SEL_OUTSTG = 3'h4;
  localparam logic [2:0] SEL_LOCKPIN = 3'h5;
  localparam int INT_LSB = 15;
  localparam int FRACTION_NUMERATOR_LSB = 3;
  localparam int PRESC_BIT = 27;
  localparam int DBUF_EN_BIT = 13;
  localparam int BOOST_BIT = 18;
  localparam int CLKMODE_LSB = 15;
  localparam int CLKDIV_LSB = 3;
  localparam int FBSEL_BIT = 23;
  localparam int OUTDIV_LSB = 20;
  localparam int MUTE_UNTIL_LOCKED_BIT = 10;
  localparam int RFEN_BIT = 5;
  localparam int PWR_LSB = 3;
  localparam int ABW_LSB = 30;
  localparam int CCE_BIT = 29;
  localparam int LDMODE_LSB = 22;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic [15:0] int_value;
    logic [11:0] fraction_numerator;
    logic prescaler_select;
    logic [11:0] fraction_modulus;
    logic boost_en;
    logic [1:0] clk_div_mode;
    logic [11:0] clk_div_value;
    logic feedback_sel;
    logic [2:0] out_div_sel;
    logic mute_until_locked;
    logic rf_out_en;
    logic [1:0] out_power;
    logic [1:0] antibacklash_width;
    logic charge_cancel_enable;
    logic [1:0] ld_pin_mode;
  } scl_cfg_t;
endpackage : scl_pkg

//--- rtl/scl_sync.sv
/*
  scl_sync: two-flop synchroniser for one pin level.
  Assumes the pin is asynchronous to i_mclk.
*/
module scl_sync (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : scl_sync

//--- rtl/scl_latches.sv
/*
  scl_latches: three-wire serial loader and destination latches of the
  synthesizer control words, with double buffering applied on channel writes.
  Assumes serial pins are slow against i_mclk (each level lasts >= 3 cycles).
*/
// Notes on behaviour
// [R1] select code 000 routes a word to the channel latch
// [R2] integer divide value is channel word bits 30..15
// [R3] host keeps integer 23..32767 with the 4/5 prescaler
// [R4] host keeps integer 75..65535 with the 8/9 prescaler
// [R5] fraction numerator is channel bits 14..3, host keeps it below modulus
// [R6] select code 001 routes a word to the modulus/phase/prescaler latch
// [R7] prescaler choice comes from bit 27 of that latch
// [R8] host picks 8/9 above 3 GHz
// [R9] double-buffered fields wait in a shadow until the next channel write
// [R10] output divider waits for channel write only when bit 13 of latch 2 set
// [R11] host sets test mux to digital lock when lock pin reports it
// [R12] lock-pin word: width 31..30, cancel 29, one at 28, pin mode 23..22
// [R13] boost word: boost 18, clock mode 16..15, divider value 14..3
// [R14] output word: feedback 23, divider 22..20, mute 10, enable 5, power 4..3
// [R15] host writes reserved bits with their fixed values
// [R16] msb first shift on serial clock rise, latch on strobe rise
// [R17] with mute enabled, rf supply stays off until digital lock
module scl_latches (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_latch_strobe,
  input wire logic i_dig_lock,
  output scl_pkg::scl_cfg_t o_cfg,
  output logic o_rf_supply_on
);
  logic sclk_s, sdata_s, le_s, lock_s;
  logic sclk_d_r, le_d_r;
  logic [31:0] shift_r;
  logic [31:0] ch_r, modph_sh_r, modph_r, cfg2_r, boost_r, out_r, out_act_r, lock_r;
  logic rf_on_r;

  scl_sync u_s_clk (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_sclk), .o_q(sclk_s));
  scl_sync u_s_dat (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_sdata), .o_q(sdata_s));
  scl_sync u_s_le (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_latch_strobe), .o_q(le_s));
  scl_sync u_s_lk (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_dig_lock), .o_q(lock_s));

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire le_rise = le_s & ~le_d_r;
  wire [2:0] sel = shift_r[2:0];
  wire wr_ch = le_rise && (sel == scl_pkg::SEL_CHANNEL); // [R1]
  wire wr_modph = le_rise && (sel == scl_pkg::SEL_MODPH); // [R6]
  wire wr_cfg2 = le_rise && (sel == scl_pkg::SEL_CFG2);
  wire wr_boost = le_rise && (sel == scl_pkg::SEL_BOOST);
  wire wr_out = le_rise && (sel == scl_pkg::SEL_OUTSTG);
  wire wr_lock = le_rise && (sel == scl_pkg::SEL_LOCKPIN);
  wire dbuf_en = cfg2_r[scl_pkg::DBUF_EN_BIT];
  wire [2:0] div_field = out_r[scl_pkg::OUTDIV_LSB +: 3];
  wire [2:0] div_act = out_act_r[scl_pkg::OUTDIV_LSB +: 3];
  wire mute_on = out_r[scl_pkg::MUTE_UNTIL_LOCKED_BIT];
  wire rf_en = out_r[scl_pkg::RFEN_BIT];
  wire rf_on_nxt = rf_en & (~mute_on | lock_s); // [R17]

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sclk_d_r <= 1'b0;
      le_d_r <= 1'b0;
      shift_r <= scl_pkg::WORD_RST;
    end else begin
      sclk_d_r <= sclk_s;
      le_d_r <= le_s;
      if (sclk_rise) begin
        shift_r <= {shift_r[30:0], sdata_s}; // [R16]
      end
    end
  end

  // stores are taken on strobe rise; word is the shifter content then
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ch_r <= scl_pkg::WORD_RST;
      modph_sh_r <= scl_pkg::WORD_RST;
      modph_r <= scl_pkg::WORD_RST;
      cfg2_r <= scl_pkg::WORD_RST;
      boost_r <= scl_pkg::WORD_RST;
      out_r <= scl_pkg::WORD_RST;
      out_act_r <= scl_pkg::WORD_RST;
      lock_r <= scl_pkg::WORD_RST;
      rf_on_r <= 1'b0;
    end else begin
      rf_on_r <= rf_on_nxt;
      if (wr_ch) begin
        ch_r <= shift_r;
      end
      if (wr_modph) begin
        modph_sh_r <= shift_r;
      end
      if (wr_ch) begin
        modph_r <= modph_sh_r; // [R9]
      end
      if (wr_cfg2) begin
        cfg2_r <= shift_r;
      end
      if (wr_boost) begin
        boost_r <= shift_r; // [R13]
      end
      if (wr_out) begin
        out_r <= shift_r; // [R14]
      end
      if (wr_lock) begin
        lock_r <= shift_r; // [R12]
      end
      // divider applies at once unless buffering is enabled
      if (wr_ch || !dbuf_en) begin
        out_act_r <= out_r; // [R10]
      end
    end
  end

  // mod and prescaler take effect on a channel write, so a shadow write
  // followed by channel write in the same frame ordering is honoured
  always_comb begin
    o_cfg = '0;
    o_cfg.int_value = ch_r[scl_pkg::INT_LSB +: 16]; // [R2]
    o_cfg.fraction_numerator = ch_r[scl_pkg::FRACTION_NUMERATOR_LSB +: 12]; // [R5]
    o_cfg.prescaler_select = modph_r[scl_pkg::PRESC_BIT]; // [R7]
    o_cfg.fraction_modulus = modph_r[scl_pkg::FRACTION_NUMERATOR_LSB +: 12];
    o_cfg.boost_en = boost_r[scl_pkg::BOOST_BIT];
    o_cfg.clk_div_mode = boost_r[scl_pkg::CLKMODE_LSB +: 2];
    o_cfg.clk_div_value = boost_r[scl_pkg::CLKDIV_LSB +: 12];
    o_cfg.feedback_sel = out_r[scl_pkg::FBSEL_BIT];
    o_cfg.out_div_sel = div_act;
    o_cfg.mute_until_locked = mute_on;
    o_cfg.rf_out_en = rf_en;
    o_cfg.out_power = out_r[scl_pkg::PWR_LSB +: 2];
    o_cfg.antibacklash_width = lock_r[scl_pkg::ABW_LSB +: 2];
    o_cfg.charge_cancel_enable = lock_r[scl_pkg::CCE_BIT];
    o_cfg.ld_pin_mode = lock_r[scl_pkg::LDMODE_LSB +: 2];
  end
  assign o_rf_supply_on = rf_on_r;

  a_chan_route: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_ch |=> ch_r == $past(shift_r)) else $error("channel word not latched"); // [R1]
  a_int_field: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_ch |=> o_cfg.int_value == $past(shift_r[30:15])) else $error("int field wrong"); // [R2]
  a_fraction_numerator_field: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_ch |=> o_cfg.fraction_numerator == $past(shift_r[14:3])) else $error("fraction_numerator wrong"); // [R5]
  a_modph_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    !wr_ch |=> $stable(modph_r)) else $error("prescaler latch changed early"); // [R9]
  a_presc_apply: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_ch && !wr_modph |=> o_cfg.prescaler_select == $past(modph_sh_r[27]))
    else $error("prescaler not applied"); // [R7]
  a_div_buffer: assert property (@(posedge i_mclk) disable iff (i_rst)
    dbuf_en && !wr_ch |=> $stable(out_act_r)) else $error("divider leaked"); // [R10]
  a_div_direct: assert property (@(posedge i_mclk) disable iff (i_rst)
    !dbuf_en |=> out_act_r == $past(out_r)) else $error("divider not direct"); // [R10]
  a_shift_msb: assert property (@(posedge i_mclk) disable iff (i_rst)
    sclk_rise |=> shift_r == {$past(shift_r[30:0]), $past(sdata_s)})
    else $error("shift wrong"); // [R16]
  a_mute_lock: assert property (@(posedge i_mclk) disable iff (i_rst)
    mute_on && !lock_s |=> !o_rf_supply_on) else $error("rf on before lock"); // [R17]
  a_out_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_out |=> o_cfg.rf_out_en == $past(shift_r[5])) else $error("output word lost"); // [R14]

  // latch routing: each store must copy the shifter and leave the others alone
  a_ch_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    !wr_ch |=> $stable(ch_r))
    else $error("channel latch changed without a write"); // [R1]
  a_modph_route: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_modph |=> modph_sh_r == $past(shift_r))
    else $error("modulus word not latched"); // [R6]
  a_modph_shadow: assert property (@(posedge i_mclk) disable iff (i_rst)
    !wr_modph |=> $stable(modph_sh_r))
    else $error("modulus shadow changed without a write"); // [R6]
  a_shift_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    !sclk_rise |=> $stable(shift_r))
    else $error("shifter moved without a clock rise"); // [R16]

  // boost and clock divider word
  a_boost_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_boost |=> o_cfg.boost_en == $past(shift_r[scl_pkg::BOOST_BIT]))
    else $error("boost bit wrong"); // [R13]
  a_clkdiv_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_boost |=> o_cfg.clk_div_value == $past(shift_r[14:3]))
    else $error("clock divider value wrong"); // [R13]
  a_clkmode_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_boost |=> o_cfg.clk_div_mode == $past(shift_r[16:15]))
    else $error("clock divider mode wrong"); // [R13]

  // lock pin word
  a_abw_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_lock |=> o_cfg.antibacklash_width == $past(shift_r[31:30]))
    else $error("antibacklash width wrong"); // [R12]
  a_cce_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_lock |=> o_cfg.charge_cancel_enable == $past(shift_r[scl_pkg::CCE_BIT]))
    else $error("charge cancel bit wrong"); // [R12]
  a_ldmode_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_lock |=> o_cfg.ld_pin_mode == $past(shift_r[23:22]))
    else $error("lock pin mode wrong"); // [R12]

  // output stage word
  a_fbsel_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_out |=> o_cfg.feedback_sel == $past(shift_r[scl_pkg::FBSEL_BIT]))
    else $error("feedback select wrong"); // [R14]
  a_power_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_out |=> o_cfg.out_power == $past(shift_r[4:3]))
    else $error("output power wrong"); // [R14]
  a_mute_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_out |=> o_cfg.mute_until_locked == $past(shift_r[scl_pkg::MUTE_UNTIL_LOCKED_BIT]))
    else $error("mute bit wrong"); // [R14]

  // supply follows enable, gated by lock only while muting
  a_supply_off: assert property (@(posedge i_mclk) disable iff (i_rst)
    !rf_en |=> !o_rf_supply_on)
    else $error("rf supply on while disabled"); // [R17]
  a_supply_on: assert property (@(posedge i_mclk) disable iff (i_rst)
    rf_en && !mute_on |=> o_rf_supply_on)
    else $error("rf supply off while enabled"); // [R17]
  a_supply_lock: assert property (@(posedge i_mclk) disable iff (i_rst)
    rf_en && lock_s |=> o_rf_supply_on)
    else $error("rf supply off after lock"); // [R17]

  c_chan_write: cover property (@(posedge i_mclk) wr_ch);
  c_modph_then_ch: cover property (@(posedge i_mclk) wr_modph ##[1:200] wr_ch);
  c_buffered_div: cover property (@(posedge i_mclk) dbuf_en && wr_out);
  c_mute_release: cover property (@(posedge i_mclk) mute_on && $rose(o_rf_supply_on));
endmodule : scl_latches

//--- bench/scl_host_model.sv
/*
  scl_host_model: host side of the three-wire serial port.
  Assumes callers enter send at a falling edge of i_mclk.
*/
module scl_host_model (
  input wire logic i_mclk,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_latch_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_latch_strobe = 1'b0;
  end
  // four cycles a level, above the three the synchronisers need
  task automatic hold();
    repeat (4) @(negedge i_mclk);
  endtask : hold
  // serial clock stands low outside frames
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      o_sdata = w[i];
      hold();
      o_sclk = 1'b1;
      hold();
      o_sclk = 1'b0;
    end
    o_sdata = ~w[0]; // no stale bit after release
    hold();
    o_latch_strobe = 1'b1;
    hold();
    o_latch_strobe = 1'b0;
    hold();
    hold();
  endtask : send
endmodule : scl_host_model

//--- bench/scl_latches_tb.sv
/*
  scl_latches_tb: random and corner writes to every latch, fields checked.
  Assumes scl_host_model drives the serial pins.
*/
module scl_latches_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_dig_lock = 1'b0;
  logic sclk, sdata, strobe, supply;
  scl_pkg::scl_cfg_t cfg;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] s = 32'hc948;
  logic [15:0] n_int;
  logic [2:0] div = 3'h0;
  always #4 i_mclk = ~i_mclk;
  scl_host_model u_scl_host_model (.i_mclk(i_mclk), .o_sclk(sclk), .o_sdata(sdata),
    .o_latch_strobe(strobe));
  scl_latches u_scl_latches (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_sdata(sdata),
    .i_latch_strobe(strobe), .i_dig_lock(i_dig_lock), .o_cfg(cfg), .o_rf_supply_on(supply));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    u_scl_host_model.send({4'h0, 1'b0, 12'h001, 12'hfff, 3'h1});
    s = xs(s);
    n_int = 16'd23 + s[15:0] % 16'd32745;
    u_scl_host_model.send({1'b0, n_int, 1'b0, s[26:16], 3'h0});
    chk(cfg.int_value, n_int);
    chk(cfg.fraction_numerator, s[26:16]);
    chk(cfg.prescaler_select, 1'b0);
    chk(cfg.fraction_modulus, 12'hfff);
    u_scl_host_model.send({4'h0, 1'b1, 12'h001, 12'hfff, 3'h1});
    chk(cfg.prescaler_select, 1'b0);
    u_scl_host_model.send({1'b0, 16'hffff, 12'h0, 3'h0});
    chk(cfg.prescaler_select, 1'b1);
    chk(cfg.int_value, 16'hffff);
    $display("test channel done");
    for (int k = 0; k < 2; k++) begin
      u_scl_host_model.send({18'h0, k[0], 6'h0, 1'b1, 3'h0, 3'h2});
      s = xs(s);
      u_scl_host_model.send({8'h0, s[0], s[3:1], 9'h0, 1'b0, 4'h0, s[4], s[6:5], 3'h4});
      chk(cfg.out_div_sel, k ? div : s[3:1]);
      chk(cfg.feedback_sel, s[0]);
      chk(cfg.rf_out_en, s[4]);
      chk(cfg.out_power, s[6:5]);
      u_scl_host_model.send({1'b0, 16'hffff, 12'h0, 3'h0});
      div = s[3:1];
      chk(cfg.out_div_sel, div);
    end
    $display("test output done");
    s = xs(s);
    u_scl_host_model.send({13'h0, s[0], 1'b0, s[2:1], s[14:3], 3'h3});
    chk(cfg.boost_en, s[0]);
    chk(cfg.clk_div_mode, s[2:1]);
    chk(cfg.clk_div_value, s[14:3]);
    u_scl_host_model.send({s[16:15], s[17], 1'b1, 4'h0, s[19:18], 19'h0, 3'h5});
    chk(cfg.antibacklash_width, s[16:15]);
    chk(cfg.charge_cancel_enable, s[17]);
    chk(cfg.ld_pin_mode, s[19:18]);
    // unused select code must not reach any latch
    u_scl_host_model.send(32'hffff_fffe);
    chk(cfg.clk_div_value, s[14:3]);
    chk(cfg.antibacklash_width, s[16:15]);
    $display("test boost lock done");
    u_scl_host_model.send({12'h0, 9'h0, 1'b1, 4'h0, 1'b1, 2'h3, 3'h4});
    chk(cfg.mute_until_locked, 1'b1);
    chk(supply, 1'b0);
    i_dig_lock = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk(supply, 1'b1);
    $display("test mute done");
    end_of_test();
  end
endmodule : scl_latches_tb
